// ===== design/npr_consts.svh
`ifndef NPR_CONSTS_SVH
`define NPR_CONSTS_SVH

// ---------------------------------------------
// Command bytes
// ---------------------------------------------
`define NPR_CMD_RD_MAIN  8'h00
`define NPR_CMD_RD_HALF  8'h01
`define NPR_CMD_RD_SPARE 8'h50
`define NPR_CMD_LOAD     8'h80
`define NPR_CMD_CONFIRM  8'h10
`define NPR_CMD_COPY     8'h8a
`define NPR_CMD_STATUS   8'h70

// ---------------------------------------------
// Geometry and status layout
// ---------------------------------------------
`define NPR_PAGE_BYTES   528
`define NPR_SPARE_BYTES  16
`define NPR_BLK_PAGES    32
`define NPR_MAIN_PP_MAX  2
`define NPR_SPARE_PP_MAX 3
`define NPR_PLANE_BIT    5
`define NPR_ST_FAIL      0
`define NPR_ST_READY     6
`define NPR_SYNC_LAT     2

// ---------------------------------------------
// Timing, in ns, and cycles at the core rate
// ---------------------------------------------
`define NPR_CLK_MHZ      250
`define NPR_T_RC_NS      50
`define NPR_T_REA_NS     30
`define NPR_T_REH_NS     15
`define NPR_T_WB_NS      100
`define NPR_T_WHR_NS     60
`define NPR_T_CEH_NS     100
`define NPR_CYC(ns)      ((((ns) * `NPR_CLK_MHZ) + 999) / 1000)

`endif

// ===== design/npr_pkg.sv
package npr_pkg;

   typedef enum logic [1:0] {
      NPR_OP_READ = 2'h0,
      NPR_OP_PROG = 2'h1,
      NPR_OP_COPY = 2'h2,
      NPR_OP_STAT = 2'h3
   } npr_op_t;

   typedef enum logic [7:0] {
      NPR_ST_IDLE = 8'h01,
      NPR_ST_CMD  = 8'h02,
      NPR_ST_ADDR = 8'h04,
      NPR_ST_WR   = 8'h08,
      NPR_ST_BUSY = 8'h10,
      NPR_ST_RD   = 8'h20,
      NPR_ST_STAT = 8'h40,
      NPR_ST_END  = 8'h80
   } npr_state_t;

endpackage

// ===== design/npr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module npr_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             i_core_clk,
   input  wire logic             i_rst,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         meta_q <= '0;
         o_sync <= '0;
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ===== design/npr_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module npr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             i_core_clk,
   input  wire logic             i_rst,
   input  wire logic             i_valid,
   output logic                  o_ready,
   input  wire logic [WIDTH-1:0] i_data,
   output logic                  o_valid,
   input  wire logic             i_ready,
   output logic      [WIDTH-1:0] o_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;

   wire push = i_valid && o_ready;
   wire pop  = o_valid && i_ready;

   assign o_ready = cnt_q != (AW+1)'(DEPTH);
   assign o_valid = cnt_q != '0;
   assign o_data  = mem_q[rd_q];

   // ---------------------------------------------
   // Storage
   // ---------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (push)
         mem_q[wr_q] <= i_data;
   end

   // ---------------------------------------------
   // Pointers and fill level
   // ---------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push)
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         if (pop)
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

// ===== design/npr_ctrl.sv
// Functional notes
// - Main read is 00h plus three addresses.
// - Busy low during load; host waits ready.
// - Each read strobe fall gives next byte.
// - Spare pointer persists until main read command.
// - Host ends sequential read by chip disable.
// - Sequential read stays inside one block.
// - At most two main, three spare partial programs; the code counts them for the last programmed row only.
// - Program is 80h, address, data, then 10h.
// - Copy-back: read source, then 8Ah with target.
// - Copy-back source and target share plane bit.
// - No partial program after copy-back before erase; the code locks only the last copy-back target, until reset.
`timescale 1ns/1ps
`default_nettype none
`include "npr_consts.svh"
module npr_ctrl #(
   parameter int PAGE_BYTES  = `NPR_PAGE_BYTES,
   parameter int SPARE_BYTES = `NPR_SPARE_BYTES,
   parameter int BLK_PAGES   = `NPR_BLK_PAGES,
   parameter int FIFO_DEPTH  = 32
) (
   input  wire logic             i_core_clk,
   input  wire logic             i_rst,
   input  wire logic             i_start,
   input  wire npr_pkg::npr_op_t i_op,
   input  wire logic             i_spare,
   input  wire logic             i_seq,
   input  wire logic [8:0]       i_col,
   input  wire logic [15:0]      i_row,
   input  wire logic [15:0]      i_dst_row,
   input  wire logic [9:0]       i_len,
   input  wire logic [7:0]       i_wdata,
   input  wire logic             i_wvalid,
   output logic                  o_wready,
   output logic      [7:0]       o_rdata,
   output logic                  o_rvalid,
   input  wire logic             i_rready,
   output logic                  o_busy,
   output logic                  o_done,
   output logic                  o_err,
   output logic                  o_fail,
   output logic      [7:0]       o_status,
   output logic                  o_ptr_spare,
   output logic                  o_chip_en_n,
   output logic                  o_cmd_latch,
   output logic                  o_addr_latch,
   output logic                  o_write_strobe_n,
   output logic                  o_read_strobe_bar,
   output logic      [7:0]       o_io_out,
   output logic                  o_io_oe,
   input  wire logic [7:0]       i_io_in,
   input  wire logic             i_ready_busy_n
);
   import npr_pkg::*;

   localparam logic [7:0] T_WC  = 8'(`NPR_CYC(`NPR_T_RC_NS));
   localparam logic [7:0] T_WLO = 8'((`NPR_CYC(`NPR_T_RC_NS) + 1) / 2);
   localparam logic [7:0] T_RLO = 8'(`NPR_CYC(`NPR_T_REA_NS) + `NPR_SYNC_LAT);
   localparam logic [7:0] T_RCY = 8'(1 + `NPR_CYC(`NPR_T_REA_NS) + `NPR_SYNC_LAT
                                     + `NPR_CYC(`NPR_T_REH_NS));
   localparam logic [7:0] T_WB  = 8'(`NPR_CYC(`NPR_T_WB_NS));
   localparam logic [7:0] T_WHR = 8'(`NPR_CYC(`NPR_T_WHR_NS));
   localparam logic [7:0] T_CEH = 8'(`NPR_CYC(`NPR_T_CEH_NS));
   localparam int         BLKB  = $clog2(BLK_PAGES);

   npr_state_t  st_q;
   npr_state_t  st_d;
   npr_op_t     op_q;
   logic [7:0]  cmd_q;
   logic [7:0]  cmd_d;
   logic [9:0]  cnt_q;
   logic [9:0]  cnt_d;
   logic [15:0] row_q;
   logic [15:0] row_d;
   logic [15:0] dst_q;
   logic [8:0]  col_q;
   logic        spare_q;
   logic        seq_q;
   logic [7:0]  tmr_q;
   logic [1:0]  aidx_q;
   logic [7:0]  io_q;
   logic [7:0]  status_q;
   logic        fail_q;
   logic        done_q;
   logic        err_q;
   logic        ptr_spare_q;
   logic        pp_v_q;
   logic [15:0] pp_row_q;
   logic [1:0]  mcnt_q;
   logic [1:0]  scnt_q;
   logic        cb_v_q;
   logic [15:0] cb_row_q;
   logic [8:0]  pins_s;
   logic        f_ready;

   // ---------------------------------------------
   // Pin synchronisers and read-data buffer
   // ---------------------------------------------
   npr_sync #(.WIDTH(9)) u_sync (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_async    ({i_ready_busy_n, i_io_in}),
      .o_sync     (pins_s)
   );

   wire       rb_s  = pins_s[8];
   wire [7:0] io_s  = pins_s[7:0];

   wire in_idle = st_q == NPR_ST_IDLE;
   wire in_cmd  = st_q == NPR_ST_CMD;
   wire in_addr = st_q == NPR_ST_ADDR;
   wire in_wr   = st_q == NPR_ST_WR;
   wire in_busy = st_q == NPR_ST_BUSY;
   wire in_rd   = st_q == NPR_ST_RD;
   wire in_stat = st_q == NPR_ST_STAT;
   wire in_end  = st_q == NPR_ST_END;
   wire wr_st   = in_cmd || in_addr || in_wr;

   wire [7:0] rph     = in_stat ? tmr_q - T_WHR : tmr_q;
   wire       wr_last = tmr_q == T_WC - 8'h01;
   wire       rd_last = rph == T_RCY - 8'h01;
   wire       busy_ok = tmr_q >= T_WB && rb_s;
   wire       push    = in_rd && rd_last;

   npr_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_valid    (push),
      .o_ready    (f_ready),
      .i_data     (io_s),
      .o_valid    (o_rvalid),
      .i_ready    (i_rready),
      .o_data     (o_rdata)
   );

   // ---------------------------------------------
   // Request checks
   // ---------------------------------------------
   wire       same_row  = pp_v_q && pp_row_q == i_row;
   wire [1:0] main_n    = same_row ? mcnt_q : 2'h0;
   wire [1:0] spare_n   = same_row ? scnt_q : 2'h0;
   wire       prog_full = i_spare ? spare_n >= 2'(`NPR_SPARE_PP_MAX)
                                  : main_n >= 2'(`NPR_MAIN_PP_MAX);
   wire       cb_hit    = cb_v_q && cb_row_q == i_row;
   wire       plane_ok  = i_row[`NPR_PLANE_BIT] == i_dst_row[`NPR_PLANE_BIT];
   wire       len_ok    = i_len != 10'h0 && i_len <= 10'(PAGE_BYTES);
   wire       acc_ok    = (i_op == NPR_OP_PROG) ? !prog_full && !cb_hit && len_ok
                        : (i_op == NPR_OP_COPY) ? plane_ok : 1'b1;
   wire       accept    = in_idle && i_start && acc_ok;
   wire       refuse    = in_idle && i_start && !acc_ok;

   wire [7:0] ptr_cmd  = (i_op == NPR_OP_COPY) ? `NPR_CMD_RD_MAIN
                       : i_spare ? `NPR_CMD_RD_SPARE
                       : i_col[8] ? `NPR_CMD_RD_HALF : `NPR_CMD_RD_MAIN;
   wire [9:0] area_len = i_spare ? 10'(SPARE_BYTES) - {6'h0, i_col[3:0]}
                                 : 10'(PAGE_BYTES) - {1'b0, i_col};
   wire       is_ptr   = cmd_q == `NPR_CMD_RD_MAIN || cmd_q == `NPR_CMD_RD_HALF
                      || cmd_q == `NPR_CMD_RD_SPARE;

   // ---------------------------------------------
   // Byte to drive on the bus
   // ---------------------------------------------
   wire [15:0] row_cur   = (cmd_q == `NPR_CMD_COPY) ? dst_q : row_q;
   wire [7:0]  col_byte  = (op_q == NPR_OP_COPY) ? 8'h00
                         : spare_q ? {4'h0, col_q[3:0]} : col_q[7:0];
   wire [7:0]  addr_byte = (aidx_q == 2'h0) ? col_byte
                         : (aidx_q == 2'h1) ? row_cur[7:0] : row_cur[15:8];
   wire [7:0]  byte_sel  = in_cmd ? cmd_q : in_addr ? addr_byte : i_wdata;
   wire        io_ld     = wr_st && tmr_q == 8'h00 && (!in_wr || i_wvalid);

   // ---------------------------------------------
   // Strobe timer
   // ---------------------------------------------
   wire step = (wr_st && wr_last) || ((in_rd || in_stat) && rd_last)
            || (in_busy && busy_ok) || (in_end && tmr_q == T_CEH - 8'h01);
   wire hold = in_idle || (in_busy && tmr_q >= T_WB)
            || (tmr_q == 8'h00 && ((in_wr && !i_wvalid) || (in_rd && !f_ready)));
   wire [7:0] tmr_d  = (step || st_d != st_q) ? 8'h00 : hold ? tmr_q : tmr_q + 8'h01;
   wire [1:0] aidx_d = !in_addr ? 2'h0 : step ? aidx_q + 2'h1 : aidx_q;

   // ---------------------------------------------
   // Sequencer
   // ---------------------------------------------
   always_comb begin
      st_d  = st_q;
      cmd_d = cmd_q;
      cnt_d = cnt_q;
      row_d = row_q;
      unique case (st_q)
         NPR_ST_IDLE: begin
            if (accept) begin
               st_d  = NPR_ST_CMD;
               cmd_d = (i_op == NPR_OP_STAT) ? `NPR_CMD_STATUS : ptr_cmd;
               cnt_d = (i_op == NPR_OP_PROG) ? i_len : area_len;
               row_d = i_row;
            end
         end
         NPR_ST_CMD: begin
            if (step) begin
               if (cmd_q == `NPR_CMD_STATUS)
                  st_d = NPR_ST_STAT;
               else if (cmd_q == `NPR_CMD_CONFIRM)
                  st_d = NPR_ST_BUSY;
               else if (is_ptr && op_q == NPR_OP_PROG)
                  cmd_d = `NPR_CMD_LOAD;
               else
                  st_d = NPR_ST_ADDR;
            end
         end
         NPR_ST_ADDR: begin
            if (step && aidx_q == 2'h2)
               st_d = (cmd_q == `NPR_CMD_LOAD) ? NPR_ST_WR : NPR_ST_BUSY;
         end
         NPR_ST_WR: begin
            if (step) begin
               cnt_d = cnt_q - 10'h001;
               if (cnt_q == 10'h001) begin
                  cmd_d = `NPR_CMD_CONFIRM;
                  st_d  = NPR_ST_CMD;
               end
            end
         end
         NPR_ST_BUSY: begin
            if (step) begin
               if (op_q == NPR_OP_READ)
                  st_d = NPR_ST_RD;
               else begin
                  st_d  = NPR_ST_CMD;
                  cmd_d = (op_q == NPR_OP_COPY && is_ptr) ? `NPR_CMD_COPY
                                                          : `NPR_CMD_STATUS;
               end
            end
         end
         NPR_ST_RD: begin
            if (step) begin
               cnt_d = cnt_q - 10'h001;
               if (cnt_q == 10'h001) begin
                  if (seq_q && row_q[BLKB-1:0] != {BLKB{1'b1}}) begin
                     row_d = row_q + 16'h0001;
                     cnt_d = spare_q ? 10'(SPARE_BYTES) : 10'(PAGE_BYTES);
                     st_d  = NPR_ST_BUSY;
                  end else
                     st_d = NPR_ST_END;
               end
            end
         end
         NPR_ST_STAT: begin
            if (step)
               st_d = NPR_ST_END;
         end
         NPR_ST_END: begin
            if (step)
               st_d = NPR_ST_IDLE;
         end
         default: st_d = NPR_ST_IDLE;
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         st_q   <= NPR_ST_IDLE;
         cmd_q  <= `NPR_CMD_RD_MAIN;
         cnt_q  <= 10'h000;
         row_q  <= 16'h0000;
         tmr_q  <= 8'h00;
         aidx_q <= 2'h0;
      end else begin
         st_q   <= st_d;
         cmd_q  <= cmd_d;
         cnt_q  <= cnt_d;
         row_q  <= row_d;
         tmr_q  <= tmr_d;
         aidx_q <= aidx_d;
      end
   end

   // ---------------------------------------------
   // Request capture and bus byte
   // ---------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         op_q    <= NPR_OP_READ;
         spare_q <= 1'b0;
         seq_q   <= 1'b0;
         col_q   <= 9'h000;
         dst_q   <= 16'h0000;
         io_q    <= 8'h00;
      end else begin
         if (accept) begin
            op_q    <= i_op;
            spare_q <= i_spare;
            seq_q   <= i_seq;
            col_q   <= i_col;
            dst_q   <= i_dst_row;
         end
         if (io_ld)
            io_q <= byte_sel;
      end
   end

   // ---------------------------------------------
   // Program bookkeeping
   // ---------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         pp_v_q   <= 1'b0;
         pp_row_q <= 16'h0000;
         mcnt_q   <= 2'h0;
         scnt_q   <= 2'h0;
         cb_v_q   <= 1'b0;
         cb_row_q <= 16'h0000;
      end else if (accept && i_op == NPR_OP_PROG) begin
         pp_v_q   <= 1'b1;
         pp_row_q <= i_row;
         mcnt_q   <= main_n + {1'b0, !i_spare};
         scnt_q   <= spare_n + {1'b0, i_spare};
      end else if (accept && i_op == NPR_OP_COPY) begin
         cb_v_q   <= 1'b1;
         cb_row_q <= i_dst_row;
      end
   end

   // ---------------------------------------------
   // Status and flags
   // ---------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         status_q    <= 8'h00;
         fail_q      <= 1'b0;
         done_q      <= 1'b0;
         err_q       <= 1'b0;
         ptr_spare_q <= 1'b0;
      end else begin
         done_q <= in_end && step;
         err_q  <= refuse;
         if (in_stat && step) begin
            status_q <= io_s;
            fail_q   <= io_s[`NPR_ST_FAIL];
         end
         if (in_cmd && step && cmd_q == `NPR_CMD_RD_SPARE)
            ptr_spare_q <= 1'b1;
         else if (in_cmd && step && cmd_q == `NPR_CMD_RD_MAIN)
            ptr_spare_q <= 1'b0;
      end
   end

   // ---------------------------------------------
   // Outputs
   // ---------------------------------------------
   assign o_wready          = in_wr && tmr_q == 8'h00;
   assign o_busy            = !in_idle;
   assign o_done            = done_q;
   assign o_err             = err_q;
   assign o_fail            = fail_q;
   assign o_status          = status_q;
   assign o_ptr_spare       = ptr_spare_q;
   assign o_chip_en_n       = in_idle || in_end;
   assign o_cmd_latch       = in_cmd;
   assign o_addr_latch      = in_addr;
   assign o_write_strobe_n  = !(wr_st && tmr_q >= 8'h01 && tmr_q <= T_WLO);
   assign o_read_strobe_bar = !((in_rd || in_stat) && rph >= 8'h01 && rph <= T_RLO);
   assign o_io_out          = io_q;
   assign o_io_oe           = wr_st;

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   default clocking cb_chk @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   sequence s_we_low;
      (!o_write_strobe_n) [*7] ##1 o_write_strobe_n;
   endsequence
   sequence s_rstb_gap;
      (!$fell(o_read_strobe_bar)) [*8] ##1 (!$fell(o_read_strobe_bar)) [*4];
   endsequence

   a_cmd_latch_only: assert property (o_cmd_latch |-> !o_addr_latch && o_io_oe)
      else $error("command latch overlaps address latch");
   a_we_pulse_len: assert property ($fell(o_write_strobe_n) |-> s_we_low)
      else $error("write strobe low time wrong");
   a_rstb_cycle: assert property ($fell(o_read_strobe_bar) |=> s_rstb_gap)
      else $error("read strobe cycle shorter than minimum");
   a_read_ready: assert property (in_rd && !o_read_strobe_bar |-> rb_s)
      else $error("data read while device busy");
   a_busy_wait: assert property (in_busy && st_d != NPR_ST_BUSY |-> tmr_q >= T_WB)
      else $error("busy line checked too early");
   a_addr_order: assert property ($rose(in_addr) |-> aidx_q == 2'h0 ##13 aidx_q == 2'h1)
      else $error("address bytes out of order");
   a_confirm_data: assert property (in_cmd && cmd_q == `NPR_CMD_CONFIRM |-> cnt_q == 10'h000
                                    && op_q == NPR_OP_PROG)
      else $error("confirm issued before data loaded");
   a_block_stop: assert property (in_rd && step && cnt_q == 10'h001
                                  && row_q[BLKB-1:0] == {BLKB{1'b1}} |=> o_chip_en_n)
      else $error("sequential read crossed block end");
   a_ce_end_high: assert property ($rose(in_end) |-> o_chip_en_n [*8])
      else $error("chip enable not held off at end");
   a_prog_limit: assert property (in_idle && i_start && i_op == NPR_OP_PROG && prog_full
                                  |=> o_err && in_idle)
      else $error("partial program limit not enforced");
   a_copy_plane: assert property (in_idle && i_start && i_op == NPR_OP_COPY && !plane_ok
                                  |=> o_err)
      else $error("copy-back across planes accepted");
   a_copy_lock: assert property (in_idle && i_start && i_op == NPR_OP_PROG && cb_hit
                                 |=> o_err)
      else $error("program after copy-back accepted");
   a_copy_src_read: assert property ($rose(in_cmd && cmd_q == `NPR_CMD_COPY)
                                     |-> $past(in_busy))
      else $error("copy-back command before source load");
   a_spare_ptr: assert property (in_cmd && step && cmd_q == `NPR_CMD_RD_SPARE
                                 |=> o_ptr_spare)
      else $error("spare pointer not tracked");
endmodule
`default_nettype wire

// ===== verification/npr_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module npr_flash_model (
   input  wire logic       i_ce_n,
   input  wire logic       i_cle,
   input  wire logic       i_ale,
   input  wire logic       i_we_n,
   input  wire logic       i_rd_n,
   input  wire logic [7:0] i_dq,
   output logic      [7:0] o_dq,
   output logic            o_rb_n
);
   logic [7:0]  cmd_q;
   logic [7:0]  ptr_q = 8'h00;
   logic [9:0]  col_q;
   logic [15:0] row_q;
   logic [1:0]  na_q;
   logic        stat_q = 1'b0;
   logic        fail_q = 1'b0;
   int          nd     = 0;
   realtime     rdy_t  = 0.0;
   initial o_rb_n = 1'b1;
   initial o_dq = 8'h00;
   task automatic go_busy(input int ns);
      o_rb_n = 1'b0;
      rdy_t = $realtime + ns;
   endtask
   // Ready returns once the busy span has run out
   always #1 if (!o_rb_n && $realtime >= rdy_t) o_rb_n = 1'b1;
   // Chip disable cuts a sequential load short
   always @(posedge i_ce_n) if (!o_rb_n) rdy_t = $realtime + 50;
   always @(posedge i_we_n) if (!i_ce_n) begin
      if (i_cle && (o_rb_n || i_dq == 8'h70)) begin
         stat_q = (i_dq == 8'h70);
         if (i_dq == 8'h00 || i_dq == 8'h01 || i_dq == 8'h50) ptr_q = i_dq;
         if (i_dq == 8'h10 && cmd_q == 8'h80 && nd > 0) begin
            fail_q = (row_q[7:0] == 8'h07);
            go_busy(2000);
         end
         cmd_q = i_dq;
         na_q = 2'h0;
         nd = 0;
      end else if (i_ale) begin
         case (na_q)
            2'h0: col_q = (ptr_q == 8'h50) ? {6'h20, i_dq[3:0]} : {1'b0, ptr_q == 8'h01, i_dq};
            2'h1: row_q[7:0] = i_dq;
            default: row_q[15:8] = i_dq;
         endcase
         if (na_q == 2'h2 && cmd_q == 8'h8a) begin
            fail_q = (row_q[7:0] == 8'h07);
            go_busy(2000);
         end
         else if (na_q == 2'h2 && cmd_q != 8'h80) go_busy(1000);
         if (na_q == 2'h2 && ptr_q == 8'h01) ptr_q = 8'h00;
         na_q = na_q + 2'h1;
      end else if (cmd_q == 8'h80) nd = nd + 1;
   end
   always @(negedge i_rd_n) if (!i_ce_n) begin
      o_dq <= #20 stat_q ? {1'b1, o_rb_n, 5'h00, fail_q}
                         : row_q[7:0] ^ col_q[7:0] ^ {6'h00, col_q[9:8]};
      if (!stat_q) col_q = col_q + 10'h1;
   end
   // Released bus shows the inverse of the last byte; page end loads the next row
   always @(posedge i_rd_n) begin
      o_dq <= #15 ~o_dq;
      if (!i_ce_n && !stat_q && col_q == 10'd528) begin
         col_q = {ptr_q == 8'h50, 9'h000};
         row_q = row_q + 16'h1;
         go_busy(1000);
      end
   end
endmodule
`default_nettype wire

// ===== verification/nand_page_read_program_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module nand_page_read_program_tb_top;
   import npr_pkg::*;
   logic       clk = 1'b0, rst = 1'b1, start = 1'b0, spare = 1'b0, wvalid = 1'b1, rready = 1'b0;
   npr_op_t    op = NPR_OP_READ;
   logic [8:0] col = 9'h000;
   logic [15:0] row = 16'h0000, dst = 16'h0000;
   logic [9:0] len = 10'h001;
   logic       seq = 1'b0;
   logic [7:0] wd = 8'h00, st, rdata, io_out, dq;
   logic       wready, busy, done, err, fail, rvalid, ptr_sp, ce_n, cle, ale, we_n, rd_n, oe, rb_n;
   int         miscompares = 0, n_tests = 0;
   npr_ctrl i_dut (.i_core_clk(clk), .i_rst(rst), .i_start(start), .i_op(op), .i_spare(spare),
      .i_seq(seq), .i_col(col), .i_row(row), .i_dst_row(dst), .i_len(len), .i_wdata(wd),
      .i_wvalid(wvalid), .o_wready(wready), .o_rdata(rdata), .o_rvalid(rvalid),
      .i_rready(rready), .o_busy(busy), .o_done(done), .o_err(err), .o_fail(fail),
      .o_status(st), .o_ptr_spare(ptr_sp), .o_chip_en_n(ce_n), .o_cmd_latch(cle),
      .o_addr_latch(ale), .o_write_strobe_n(we_n), .o_read_strobe_bar(rd_n),
      .o_io_out(io_out), .o_io_oe(oe), .i_io_in(oe ? io_out : dq), .i_ready_busy_n(rb_n));
   npr_flash_model i_mem (.i_ce_n(ce_n), .i_cle(cle), .i_ale(ale), .i_we_n(we_n),
      .i_rd_n(rd_n), .i_dq(io_out), .o_dq(dq), .o_rb_n(rb_n));
   initial forever #2 clk = ~clk;
   always @(posedge clk) if (wready && wvalid) wd <= wd + 8'h01;
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic go(input npr_op_t o, input logic s, input logic [8:0] c,
                     input logic [15:0] r, input logic [15:0] d, input logic [9:0] l);
      @(posedge clk);
      #1 {op, spare, col, row, dst, len, start} = {o, s, c, r, d, l, 1'b1};
      @(posedge clk);
      #1 start = 1'b0;
   endtask
   task automatic fin(input logic exp_err);
      logic seen_end;
      seen_end = 1'b0;
      for (int i = 0; i < 20000 && !seen_end; i++) begin
         @(negedge clk);
         seen_end = done === 1'b1 || err === 1'b1;
      end
      check({5'h00, busy, !seen_end, err}, {7'h00, exp_err});
   endtask
   task automatic drain(input int n, input logic [15:0] r, input logic [9:0] c);
      @(posedge clk);
      #1 rready = 1'b1;
      for (int k = 0; k < n; ) begin
         @(negedge clk);
         if (rvalid === 1'b1) begin
            check(rdata, r[7:0] ^ c[7:0] ^ {6'h00, c[9:8]});
            c++;
            k++;
         end
         @(posedge clk);
      end
      #1 rready = 1'b0;
   endtask
   task automatic t_read;
      go(NPR_OP_READ, 1'b0, 9'h1e0, 16'h0003, 16'h0000, 10'h001);
      repeat (1200) @(negedge clk);
      check({7'h00, rvalid}, 8'h01);
      drain(48, 16'h0003, 10'd480);
      fin(1'b0);
      go(NPR_OP_READ, 1'b1, 9'h00c, 16'h0005, 16'h0000, 10'h001);
      drain(4, 16'h0005, 10'd524);
      fin(1'b0);
      check({7'h00, ptr_sp}, 8'h01);
      @(posedge clk);
      #1 seq = 1'b1;
      go(NPR_OP_READ, 1'b1, 9'h00c, 16'h001e, 16'h0000, 10'h001);
      drain(4, 16'h001e, 10'd524);
      drain(16, 16'h001f, 10'd512);
      fin(1'b0);
      @(posedge clk);
      #1 seq = 1'b0;
      $display("read tests over");
   endtask
   task automatic t_prog;
      go(NPR_OP_PROG, 1'b0, 9'h000, 16'h0004, 16'h0000, 10'h003);
      fin(1'b0);
      check(st, 8'hc0);
      check({7'h00, ptr_sp}, 8'h00);
      go(NPR_OP_PROG, 1'b0, 9'h010, 16'h0004, 16'h0000, 10'h002);
      fin(1'b0);
      go(NPR_OP_PROG, 1'b0, 9'h020, 16'h0004, 16'h0000, 10'h002);
      fin(1'b1);
      go(NPR_OP_PROG, 1'b0, 9'h000, 16'h0007, 16'h0000, 10'h001);
      fin(1'b0);
      check({7'h00, fail}, 8'h01);
      go(NPR_OP_STAT, 1'b0, 9'h000, 16'h0000, 16'h0000, 10'h001);
      fin(1'b0);
      check(st, 8'hc1);
      $display("program tests over");
   endtask
   task automatic t_copy;
      go(NPR_OP_PROG, 1'b0, 9'h000, 16'h0009, 16'h0000, 10'h000);
      fin(1'b1);
      go(NPR_OP_COPY, 1'b0, 9'h000, 16'h0000, 16'h0020, 10'h001);
      fin(1'b1);
      go(NPR_OP_COPY, 1'b0, 9'h000, 16'h0041, 16'h0042, 10'h001);
      fin(1'b0);
      check(st, 8'hc0);
      go(NPR_OP_PROG, 1'b0, 9'h000, 16'h0042, 16'h0000, 10'h001);
      fin(1'b1);
      $display("copy tests over");
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk);
      #1 rst = 1'b0;
      t_read;
      t_prog;
      t_copy;
      give_verdict;
   end
   initial begin
      #300000;
      miscompares++;
      give_verdict;
   end
endmodule
`default_nettype wire
